/* File: verilog/scu_pkg.sv */
// constants, states and the register map of the stream cipher unit
// What this block does
// - soft reset bit acts as full reset
// - soft reset bit clears after one cycle
// - mask gates only the interrupt pin
// - every reset sets the interrupt mask
// - any clear-register write drops interrupt flag, except in a cycle with a completion event
// - key length: four bits, bytes minus one
// - key length write starts the permutation
// - key held in four words, low first
// - count register: bytes minus one, last bit
// - sub-messages default to four bytes
// - after last sub-message, reinitialize; keep result
// - message write starts processing, one shared path
// - unprocessed result bits copy the input
// - pointer register holds both indices, saved
// - substitution memory: 64 words, saved, restored
// - interrupt flag on every completion event
// - busy while not idle or context access
package scu_pkg;
  // ---------------------------------------------------------------
  // word addresses on the host port
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h400;
  localparam logic [11:0] ADDR_STATUS = 12'h401;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h402;
  localparam logic [11:0] ADDR_KEY_LEN = 12'h403;
  localparam logic [11:0] ADDR_KEY0 = 12'h404;
  localparam logic [11:0] ADDR_COUNT = 12'h408;
  localparam logic [11:0] ADDR_MSG = 12'h409;
  localparam logic [11:0] ADDR_RESULT = 12'h40a;
  localparam logic [11:0] ADDR_PTR = 12'h40b;
  localparam logic [11:0] ADDR_SBOX_FIRST = 12'h410;
  localparam logic [11:0] ADDR_SBOX_LAST = 12'h50c;
  // ---------------------------------------------------------------
  // field positions (bit 0 is the least significant bit)
  // ---------------------------------------------------------------
  localparam int CTRL_MASK_BIT = 0;
  localparam int CTRL_SRST_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_IRQ_BIT = 1;
  localparam int ST_INIT_BIT = 2;
  localparam int ST_PERM_BIT = 3;
  localparam int ST_SUB_BIT = 4;
  localparam int ST_FULL_BIT = 5;
  localparam int ST_EMPTY_BIT = 6;
  localparam int CNT_LAST_BIT = 2;
  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [2:0] COUNT_RESET = 3'h3;
  localparam logic [3:0] KEY_LEN_RESET = 4'hf;
  localparam logic [7:0] SBOX_LAST_IDX = 8'hff;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 35;
  // ---------------------------------------------------------------
  // engine states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_INIT = 3'b000,
    S_WAIT_KEY = 3'b001,
    S_PERM = 3'b010,
    S_READY = 3'b011,
    S_MSG = 3'b100
  } scu_state_type;
endpackage

/* File: verilog/scu_fifo.sv */
// word FIFO in front of the cipher engine
`timescale 1ns/1ps
module scu_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  // full when pointers differ only in the wrap bit
  assign in_ready_out = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
  assign out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];
  // pointer update
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
  // storage, no reset needed
  always_ff @(posedge clk_sys_in) begin
    if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
  end
endmodule // scu_fifo

/* File: verilog/scu_irq_ctrl.sv */
// sticky interrupt flag and masked interrupt pin
`timescale 1ns/1ps
module scu_irq_ctrl (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic event_in,
  input wire logic clear_in,
  input wire logic mask_in,
  output logic flag_out,
  output logic irq_n_out
);
  logic flag_reg;
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) flag_reg <= 1'b0;
    else if (event_in) flag_reg <= 1'b1;
    else if (clear_in) flag_reg <= 1'b0;
  end
  assign flag_out = flag_reg;
  // mask only blocks the pin, never the flag
  assign irq_n_out = !(flag_reg && !mask_in);
endmodule // scu_irq_ctrl

/* File: verilog/scu_core.sv */
// register-driven stream cipher engine with context save and restore
`timescale 1ns/1ps
module scu_core
  import scu_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [11:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out,
  output logic msg_ready_out,
  output logic irq_n_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  scu_state_type state_reg;
  logic soft_rst_reg;
  logic mask_reg;
  logic [3:0] key_len_reg;
  logic [31:0] key_reg [0:3];
  logic [2:0] count_reg;
  logic [31:0] result_reg;
  logic [31:0] work_reg;
  logic [7:0] i_reg;
  logic [7:0] j_reg;
  logic [7:0] cnt_reg;
  logic [3:0] kidx_reg;
  logic [1:0] byte_idx_reg;
  logic [1:0] nbytes_reg;
  logic last_reg;
  logic perm_pend_reg;
  logic init_done_reg;
  logic perm_done_reg;
  logic sub_done_reg;
  logic full_done_reg;
  logic [31:0] rdata_reg;
  logic [7:0] sbox_reg [0:255];
  logic irq_flag;
  logic fifo_valid;
  logic [FIFO_WIDTH-1:0] fifo_data;
  // ---------------------------------------------------------------
  // reset and address decode
  // ---------------------------------------------------------------
  // soft reset folds into the same synchronous reset as the pin
  wire int_rst_n = rst_n_in && !soft_rst_reg;
  wire hit_ctrl = addr_in == ADDR_CTRL;
  wire hit_status = addr_in == ADDR_STATUS;
  wire hit_clr = addr_in == ADDR_IRQ_CLR;
  wire hit_klen = addr_in == ADDR_KEY_LEN;
  wire hit_key = addr_in[11:2] == ADDR_KEY0[11:2];
  wire hit_count = addr_in == ADDR_COUNT;
  wire hit_msg = addr_in == ADDR_MSG;
  wire hit_result = addr_in == ADDR_RESULT;
  wire hit_ptr = addr_in == ADDR_PTR;
  wire hit_sbox = (addr_in >= ADDR_SBOX_FIRST) && (addr_in <= ADDR_SBOX_LAST) && (addr_in[1:0] == 2'b00);
  wire [11:0] sbox_off = addr_in - ADDR_SBOX_FIRST;
  wire [5:0] sbox_word = sbox_off[7:2];
  wire wr_ctrl = wr_en_in && hit_ctrl;
  wire wr_clr = wr_en_in && hit_clr;
  wire wr_klen = wr_en_in && hit_klen;
  wire wr_msg = wr_en_in && hit_msg;
  wire wr_ptr = wr_en_in && hit_ptr;
  wire wr_sbox = wr_en_in && hit_sbox;
  wire rd_result = rd_en_in && hit_result;
  wire ctx_access = (wr_en_in || rd_en_in) && (hit_ptr || hit_sbox);
  // ---------------------------------------------------------------
  // keystream datapath
  // ---------------------------------------------------------------
  // key byte n sits in word n/4, lane n%4, low lane first
  wire [31:0] key_word = key_reg[kidx_reg[3:2]];
  wire [7:0] key_byte = key_word[{kidx_reg[1:0], 3'b000} +: 8];
  wire in_perm = state_reg == S_PERM;
  wire in_msg = state_reg == S_MSG;
  wire [7:0] a_idx = in_perm ? cnt_reg : 8'(i_reg + 8'h01);
  wire [7:0] a_val = sbox_reg[a_idx];
  wire [7:0] b_idx = in_perm ? 8'(j_reg + a_val + key_byte) : 8'(j_reg + a_val);
  wire [7:0] b_val = sbox_reg[b_idx];
  // keystream index after the swap; entries a and b hold swapped values
  wire [7:0] t_idx = 8'(a_val + b_val);
  wire [7:0] ks_byte = (t_idx == a_idx) ? b_val : (t_idx == b_idx) ? a_val : sbox_reg[t_idx];
  wire [7:0] in_byte = work_reg[{byte_idx_reg, 3'b000} +: 8];
  wire [7:0] out_byte = in_byte ^ ks_byte;
  wire msg_end = in_msg && (byte_idx_reg == nbytes_reg);
  // bytes past the count keep the value written by the host
  logic [31:0] merged;
  always_comb begin
    merged = work_reg;
    merged[{byte_idx_reg, 3'b000} +: 8] = out_byte;
  end
  // ---------------------------------------------------------------
  // completion events and the FIFO hand-off
  // ---------------------------------------------------------------
  wire init_end = (state_reg == S_INIT) && (cnt_reg == SBOX_LAST_IDX);
  wire perm_end = in_perm && (cnt_reg == SBOX_LAST_IDX);
  wire start_msg = (state_reg == S_READY) && !perm_pend_reg && fifo_valid;
  wire done_event = init_end || perm_end || msg_end;
  wire busy = (state_reg == S_INIT) || in_perm || in_msg || ctx_access;
  // entry carries the count register snapshot with the word
  wire [FIFO_WIDTH-1:0] fifo_in = {count_reg, wdata_in};
  scu_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(int_rst_n),
    .in_valid_in(wr_msg),
    .in_ready_out(msg_ready_out),
    .in_data_in(fifo_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(start_msg),
    .out_data_out(fifo_data)
  );
  scu_irq_ctrl u_irq (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(int_rst_n),
    .event_in(done_event),
    .clear_in(wr_clr),
    .mask_in(mask_reg),
    .flag_out(irq_flag),
    .irq_n_out(irq_n_out)
  );
  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // only the two defined bits are stored
  always_ff @(posedge clk_sys_in) begin
    if (!int_rst_n) begin
      soft_rst_reg <= 1'b0;
      mask_reg <= 1'b1;
    end else if (wr_ctrl) begin
      soft_rst_reg <= wdata_in[CTRL_SRST_BIT];
      mask_reg <= wdata_in[CTRL_MASK_BIT];
    end
  end
  // ---------------------------------------------------------------
  // key and count registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!int_rst_n) begin
      key_len_reg <= KEY_LEN_RESET;
      for (int k = 0; k < 4; k++) key_reg[k] <= '0;
    end else begin
      if (wr_klen) key_len_reg <= wdata_in[3:0];
      if (wr_en_in && hit_key) key_reg[addr_in[1:0]] <= wdata_in;
    end
  end
  // count returns to four bytes once the last sub-message is done
  always_ff @(posedge clk_sys_in) begin
    if (!int_rst_n) count_reg <= COUNT_RESET;
    else if (wr_en_in && hit_count) count_reg <= wdata_in[2:0];
    else if (msg_end && last_reg) count_reg <= COUNT_RESET;
  end
  // ---------------------------------------------------------------
  // engine state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!int_rst_n) begin
      state_reg <= S_INIT;
      cnt_reg <= '0;
      kidx_reg <= '0;
      i_reg <= '0;
      j_reg <= '0;
      perm_pend_reg <= 1'b0;
      byte_idx_reg <= '0;
      nbytes_reg <= '0;
      last_reg <= 1'b0;
      work_reg <= '0;
      result_reg <= '0;
    end else begin
      if (wr_klen) perm_pend_reg <= 1'b1;
      case (state_reg)
        S_INIT: begin
          cnt_reg <= 8'(cnt_reg + 8'h01);
          if (init_end) state_reg <= S_WAIT_KEY;
        end
        S_WAIT_KEY: begin
          if (perm_pend_reg || wr_klen) begin
            state_reg <= S_PERM;
            perm_pend_reg <= 1'b0;
            cnt_reg <= '0;
            kidx_reg <= '0;
            j_reg <= '0;
          end
        end
        S_PERM: begin
          cnt_reg <= 8'(cnt_reg + 8'h01);
          kidx_reg <= (kidx_reg == key_len_reg) ? 4'h0 : 4'(kidx_reg + 4'h1);
          j_reg <= b_idx;
          if (perm_end) begin
            state_reg <= S_READY;
            i_reg <= '0;
            j_reg <= '0;
          end
        end
        S_READY: begin
          // a new key throws away the permuted memory
          if (perm_pend_reg) begin
            state_reg <= S_INIT;
            cnt_reg <= '0;
          end else if (start_msg) begin
            state_reg <= S_MSG;
            work_reg <= fifo_data[31:0];
            nbytes_reg <= fifo_data[33:32];
            last_reg <= fifo_data[32 + CNT_LAST_BIT] && 1'b1;
            byte_idx_reg <= '0;
          end
        end
        S_MSG: begin
          i_reg <= a_idx;
          j_reg <= b_idx;
          work_reg <= merged;
          byte_idx_reg <= 2'(byte_idx_reg + 2'h1);
          if (msg_end) begin
            result_reg <= merged;
            if (last_reg) begin
              // restart from a fresh memory, result stays readable
              state_reg <= S_INIT;
              cnt_reg <= '0;
              i_reg <= '0;
              j_reg <= '0;
            end else begin
              state_reg <= S_READY;
            end
          end
        end
        default: state_reg <= S_INIT;
      endcase
      // context restore loads both indices and returns the engine to the ready state
      if (wr_ptr) begin
        i_reg <= wdata_in[15:8];
        j_reg <= wdata_in[7:0];
        state_reg <= S_READY;
      end
    end
  end
  // ---------------------------------------------------------------
  // substitution memory: engine swaps and host context access
  // ---------------------------------------------------------------
  // no reset: the init state rebuilds the table after any reset
  always_ff @(posedge clk_sys_in) begin
    if (state_reg == S_INIT) begin
      sbox_reg[cnt_reg] <= cnt_reg;
    end else if (in_perm || in_msg) begin
      sbox_reg[a_idx] <= b_val;
      sbox_reg[b_idx] <= a_val;
    end else if (wr_sbox) begin
      for (int k = 0; k < 4; k++) sbox_reg[{sbox_word, 2'(k)}] <= wdata_in[8*k +: 8];
    end
  end
  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!int_rst_n) begin
      init_done_reg <= 1'b0;
      perm_done_reg <= 1'b0;
      sub_done_reg <= 1'b0;
      full_done_reg <= 1'b0;
    end else begin
      if (init_end) init_done_reg <= 1'b1;
      else if (in_perm) init_done_reg <= 1'b0;
      if (perm_end) perm_done_reg <= 1'b1;
      else if (start_msg) perm_done_reg <= 1'b0;
      if (msg_end) sub_done_reg <= 1'b1;
      else if (start_msg) sub_done_reg <= 1'b0;
      // completion wins over a clearing read in the same cycle
      if (msg_end && last_reg) full_done_reg <= 1'b1;
      else if (wr_klen || rd_result) full_done_reg <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // read path, one cycle latency
  // ---------------------------------------------------------------
  wire [31:0] status_word = {25'h0, !fifo_valid, full_done_reg, sub_done_reg, perm_done_reg,
    init_done_reg, irq_flag, busy};
  wire [31:0] sbox_rd = {sbox_reg[{sbox_word, 2'h3}], sbox_reg[{sbox_word, 2'h2}],
    sbox_reg[{sbox_word, 2'h1}], sbox_reg[{sbox_word, 2'h0}]};
  wire [31:0] ctrl_rd = {30'h0, soft_rst_reg, mask_reg};
  // write-only and unmapped words read as zero
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
    hit_status ? status_word :
    hit_result ? result_reg :
    hit_ptr ? {16'h0000, i_reg, j_reg} :
    hit_sbox ? sbox_rd : 32'h00000000;
  always_ff @(posedge clk_sys_in) begin
    if (!int_rst_n) rdata_reg <= '0;
    else if (rd_en_in) rdata_reg <= rd_mux;
  end
  assign rdata_out = rdata_reg;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // soft and hardware reset
  a_soft_rst_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    soft_rst_reg |=> !soft_rst_reg)
    else $error("soft reset bit did not clear itself");
  a_soft_rst_effect: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    soft_rst_reg |=> (state_reg == S_INIT) && (cnt_reg == 8'h00) && !full_done_reg && !irq_flag)
    else $error("soft reset did not act as a full reset");
  a_reset_mask_set: assert property (@(posedge clk_sys_in)
    (!rst_n_in || soft_rst_reg) |=> mask_reg && irq_n_out)
    else $error("reset left the interrupt pin enabled");
  // interrupt flag and pin; the mask must never touch the flag
  a_mask_gate_pin: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (irq_flag && !mask_reg) |-> !irq_n_out)
    else $error("interrupt pin not driven by unmasked flag");
  a_mask_block_pin: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    mask_reg |-> irq_n_out)
    else $error("masked interrupt reached the pin");
  a_mask_keeps_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_ctrl && !done_event && !wr_clr && !soft_rst_reg) |=> (irq_flag == $past(irq_flag)))
    else $error("control write changed the interrupt flag");
  a_irq_clear_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_clr && !done_event && !soft_rst_reg) |=> !irq_flag && irq_n_out)
    else $error("interrupt clear write did not clear flag and pin");
  a_event_sets_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (done_event && !soft_rst_reg) |=> irq_flag)
    else $error("completion did not raise the interrupt flag");
  // engine sequencing and context restore
  a_init_done: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (init_end && !soft_rst_reg && !wr_ptr) |=> (state_reg == S_WAIT_KEY) && init_done_reg && irq_flag)
    else $error("initialization end did not raise its flags");
  a_key_len_start: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_klen && (state_reg == S_WAIT_KEY) && !soft_rst_reg && !wr_ptr) |=> in_perm ##255 perm_end)
    else $error("key length write did not run a full permutation");
  a_msg_start: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (start_msg && !soft_rst_reg && !wr_ptr) |=> in_msg ##[0:3] msg_end)
    else $error("message did not finish within four bytes");
  a_last_reinit: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (msg_end && last_reg && !soft_rst_reg && !wr_ptr) |=> (state_reg == S_INIT) && full_done_reg
      && (result_reg == $past(merged)))
    else $error("last sub-message did not restart initialization");
  a_busy_engine: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (in_msg || in_perm || ctx_access) |=> rdata_reg[ST_BUSY_BIT] || !$past(rd_en_in && hit_status))
    else $error("busy bit low while the engine works");
  a_ptr_restore: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_ptr && !soft_rst_reg) |=> ({16'h0000, i_reg, j_reg} == ($past(wdata_in) & 32'h0000ffff)))
    else $error("pointer write did not restore both indices");
endmodule // scu_core

/* File: test/scu_host_model.sv */
// host processor model that drives the register port
`timescale 1ns/1ps
module scu_host_model (
  input wire logic clk_sys_in,
  output logic [11:0] addr_out,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [31:0] wdata_out,
  input wire logic [31:0] rdata_in
);
  // idle bus from time zero
  initial begin
    addr_out = 12'h000;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    wdata_out = 32'h00000000;
  end
  // one-cycle write strobe launched at the falling edge
  task automatic write_reg(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_sys_in);
    addr_out = a;
    wdata_out = d;
    wr_en_out = 1'b1;
    @(negedge clk_sys_in);
    wr_en_out = 1'b0;
    wdata_out = ~d; // stale data must never look valid
  endtask
  // read data is registered, so it has settled by the next falling edge
  task automatic read_reg(input logic [11:0] a, output logic [31:0] d);
    @(negedge clk_sys_in);
    addr_out = a;
    rd_en_out = 1'b1;
    @(negedge clk_sys_in);
    rd_en_out = 1'b0;
    d = rdata_in;
  endtask
endmodule // scu_host_model

/* File: test/stream_cipher_unit_regs_tb_top.sv */
// self-checking bench for the stream cipher engine
`timescale 1ns/1ps
module stream_cipher_unit_regs_tb_top;
  import scu_pkg::*;
  logic clk_sys_in;
  logic rst_n_in;
  logic [11:0] addr;
  logic wr_en;
  logic rd_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic msg_ready;
  logic irq_n;
  logic [31:0] rv;
  logic [31:0] ev;
  logic [7:0] sb [256];
  int si;
  int sj;
  int failures;
  int n_checks;
  // 25 MHz system clock
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  scu_core DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .wdata_in(wdata), .rdata_out(rdata), .msg_ready_out(msg_ready), .irq_n_out(irq_n));
  scu_host_model host (.clk_sys_in(clk_sys_in), .addr_out(addr), .wr_en_out(wr_en), .rd_en_out(rd_en),
    .wdata_out(wdata), .rdata_in(rdata));
  // ---------------------------------------------------------------
  // compare, wait and reference helpers
  // ---------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %b", $time, what, got);
    end
  endtask
  // bounded status poll until the masked bits match
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      host.read_reg(ADDR_STATUS, rv);
      n++;
    end while ((rv & m) !== v && n < 3000);
    chk_reg(rv & m, v, "status wait");
  endtask
  // reference key schedule for a key of bytes 1, 2, 3 ... len
  task automatic ref_key_sched(input int len);
    logic [7:0] t;
    for (int n = 0; n < 256; n++) sb[n] = n[7:0];
    sj = 0;
    for (int n = 0; n < 256; n++) begin
      sj = (sj + sb[n] + (n % len) + 1) % 256;
      t = sb[n];
      sb[n] = sb[sj];
      sb[sj] = t;
    end
    si = 0;
    sj = 0;
  endtask
  // reference transform; untouched upper bytes copy the input
  task automatic crypt(input logic [31:0] d, input int nb, output logic [31:0] r);
    logic [7:0] t;
    r = d;
    for (int b = 0; b < nb; b++) begin
      si = (si + 1) % 256;
      sj = (sj + sb[si]) % 256;
      t = sb[si];
      sb[si] = sb[sj];
      sb[sj] = t;
      r[8*b+:8] = d[8*b+:8] ^ sb[8'(sb[si] + sb[sj])];
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    failures = 0;
    n_checks = 0;
    rst_n_in = 1'b0;
    repeat (10) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    wait_st(32'h5, 32'h4);
    host.read_reg(ADDR_CTRL, rv);
    chk_reg(rv, 32'h1, "control after reset");
    chk_pin(irq_n, 1'b1, "pin masked after reset");
    chk_pin(msg_ready, 1'b1, "buffer has room after reset");
    host.read_reg(ADDR_STATUS, rv);
    chk_reg(rv & 32'h2, 32'h2, "init raises flag");
    host.read_reg(12'h40c, rv);
    chk_reg(rv, 32'h0, "unmapped read");
    host.write_reg(ADDR_KEY0, 32'h04030201);
    host.read_reg(ADDR_KEY0, rv);
    chk_reg(rv, 32'h0, "write-only key read");
    host.write_reg(ADDR_CTRL, 32'hfffffffc);
    host.read_reg(ADDR_CTRL, rv);
    chk_reg(rv, 32'h0, "reserved control bits");
    chk_pin(irq_n, 1'b0, "unmasked pin");
    host.read_reg(ADDR_STATUS, rv);
    chk_reg(rv & 32'h2, 32'h2, "flag kept by unmask");
    host.write_reg(ADDR_IRQ_CLR, 32'h5a5a5a5a);
    chk_pin(irq_n, 1'b1, "cleared pin");
    host.read_reg(ADDR_STATUS, rv);
    chk_reg(rv & 32'h2, 32'h0, "cleared flag");
    $display("test reset_and_irq done");
    // messages wait in the buffer until a key exists; the ninth is refused
    for (int k = 0; k < 9; k++) host.write_reg(ADDR_MSG, 32'h01020304 + k * 32'h10101010);
    chk_pin(msg_ready, 1'b0, "full buffer refuses");
    host.write_reg(ADDR_KEY0, 32'h04030201);
    host.write_reg(ADDR_KEY0 + 12'h1, 32'h00000005);
    host.write_reg(ADDR_KEY_LEN, 32'h00000004);
    ref_key_sched(5);
    for (int k = 0; k < 8; k++) crypt(32'h01020304 + k * 32'h10101010, 4, ev);
    wait_st(32'h51, 32'h50);
    host.read_reg(ADDR_RESULT, rv);
    chk_reg(rv, ev, "eighth word result");
    chk_pin(irq_n, 1'b0, "completion drives pin");
    host.read_reg(ADDR_PTR, rv);
    chk_reg(rv, {16'h0000, si[7:0], sj[7:0]}, "pointer register");
    host.read_reg(ADDR_SBOX_FIRST + 12'h4, rv);
    chk_reg(rv, {sb[7], sb[6], sb[5], sb[4]}, "substitution word one");
    $display("test buffer_and_stream done");
    // two-byte last sub-message
    host.write_reg(ADDR_COUNT, 32'h00000005);
    host.write_reg(ADDR_MSG, 32'haabbccdd);
    crypt(32'haabbccdd, 2, ev);
    wait_st(32'h21, 32'h21);
    host.read_reg(ADDR_RESULT, rv);
    chk_reg(rv, ev, "partial last result");
    $display("test last_partial done");
    // soft reset behaves like the reset pin
    host.write_reg(ADDR_CTRL, 32'h00000002);
    host.read_reg(ADDR_CTRL, rv);
    chk_reg(rv, 32'h1, "soft reset self clears");
    chk_pin(irq_n, 1'b1, "soft reset masks pin");
    host.read_reg(ADDR_STATUS, rv);
    chk_reg(rv & 32'h3f, 32'h1, "soft reset status");
    wait_st(32'h7, 32'h6);
    $display("test soft_reset done");
    // context restore while the engine is idle
    host.write_reg(ADDR_SBOX_FIRST + 12'h4, 32'h11223344);
    host.read_reg(ADDR_SBOX_FIRST + 12'h4, rv);
    chk_reg(rv, 32'h11223344, "restored substitution word");
    host.write_reg(ADDR_PTR, 32'h00001234);
    host.read_reg(ADDR_PTR, rv);
    chk_reg(rv, 32'h00001234, "restored pointer");
    host.read_reg(ADDR_STATUS, rv);
    chk_reg(rv & 32'h1, 32'h0, "idle after restore");
    $display("test context_restore done");
    stop_test();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    failures++;
    $display("wrong value at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // stream_cipher_unit_regs_tb_top
